//--- logic/av_link_switch_control.sv
`timescale 1ns/1ns
`include "av_switch_map.svh"
// Behaviour
// - Slave address 100100X, X from strap pin
// - Override zero selects automatic input termination
// - Auto mode: selected source terminations on only
// - Override one: per-channel termination bits apply
// - One boost select bit per input channel
// - Boost selects reset to higher level
// - One bit switches output back-terminations
// - Back-terminations on after reset
// - Output enable clear tristates high-speed outputs
// - Current level bit, higher after reset
// - Two-bit field selects four pre-emphasis levels
// - High-speed select routes chosen source
// - Aux select routes chosen display-data bus
// - Channel switch pulses hot-plug outputs low
// - Hot-plug idle released, low over minimum time
// - Follow bit makes aux track high-speed write
// - Active-high reset restores all defaults
module av_link_switch_control #(
    parameter int unsigned HPD_CYCLES = `HPD_LOW_CYCLES,
    parameter int unsigned CHANNELS = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration pins
    input wire logic addr_select,
    output logic [6:0] slave_addr,
    // Configuration write strobes from the serial port
    input wire logic wr_rx,
    input wire logic rx_term_override_in,
    input wire logic [2*CHANNELS-1:0] rx_term_per_channel_in,
    input wire logic [2*CHANNELS-1:0] rx_boost_select_in,
    input wire logic wr_tx,
    input wire logic tx_backterm_enable_in,
    input wire logic hs_output_enable_in,
    input wire logic tx_current_level_in,
    input wire logic [1:0] tx_preemph_level_in,
    input wire logic wr_hs,
    input wire logic hs_source_select_in,
    input wire logic wr_aux,
    input wire logic aux_source_select_in,
    input wire logic aux_follow_hs_in,
    // Analog control outputs
    output logic [2*CHANNELS-1:0] rx_term_on,
    output logic [2*CHANNELS-1:0] rx_boost_select,
    output logic tx_backterm_enable,
    output logic hs_output_enable,
    output logic tx_current_level,
    output logic [1:0] tx_preemph_level,
    output logic hs_source_select,
    output logic aux_source_select,
    // Hot-plug pins, open drain: output enable pulls low
    output logic hpd_a_out,
    output logic hpd_a_oe,
    output logic hpd_b_out,
    output logic hpd_b_oe
);
    // ==================================================================
    // Configuration state
    logic rx_term_override;
    logic [2*CHANNELS-1:0] rx_term_per_channel;
    logic aux_follow_hs;
    logic [6:0] addr;
    logic next_override;
    logic [2*CHANNELS-1:0] next_per_channel;
    logic [2*CHANNELS-1:0] next_boost;
    logic next_backterm;
    logic next_hs_oe;
    logic next_current;
    logic [1:0] next_preemph;
    logic next_hs_source;
    logic next_aux_source;
    logic next_aux_follow;
    logic [6:0] next_addr;

    // Write decode; follow bit forces aux onto each high-speed write
    always_comb begin
        next_override = rx_term_override;
        next_per_channel = rx_term_per_channel;
        next_boost = rx_boost_select;
        next_backterm = tx_backterm_enable;
        next_hs_oe = hs_output_enable;
        next_current = tx_current_level;
        next_preemph = tx_preemph_level;
        next_hs_source = hs_source_select;
        next_aux_source = aux_source_select;
        next_aux_follow = aux_follow_hs;
        next_addr = {`SLAVE_ADDR_HIGH, addr_select};
        if (wr_rx) begin
            next_override = rx_term_override_in;
            next_per_channel = rx_term_per_channel_in;
            next_boost = rx_boost_select_in;
        end
        if (wr_tx) begin
            next_backterm = tx_backterm_enable_in;
            next_hs_oe = hs_output_enable_in;
            next_current = tx_current_level_in;
            next_preemph = tx_preemph_level_in;
        end
        if (wr_aux) begin
            next_aux_source = aux_source_select_in;
            next_aux_follow = aux_follow_hs_in;
        end
        if (wr_hs) begin
            next_hs_source = hs_source_select_in;
            if (next_aux_follow) begin
                next_aux_source = hs_source_select_in;
            end
        end
    end

    // Registers; strap is sampled every clock, never under reset
    always_ff @(posedge clk) begin
        addr <= next_addr;
        if (rst) begin
            rx_term_override <= `RST_TERM_OVERRIDE;
            rx_term_per_channel <= `RST_TERM_PER_CHANNEL;
            rx_boost_select <= `RST_BOOST_SELECT;
            tx_backterm_enable <= `RST_BACKTERM;
            hs_output_enable <= `RST_HS_OE;
            tx_current_level <= `RST_CURRENT_LEVEL;
            tx_preemph_level <= `RST_PREEMPH;
            hs_source_select <= `RST_HS_SOURCE;
            aux_source_select <= `RST_AUX_SOURCE;
            aux_follow_hs <= `RST_AUX_FOLLOW;
        end else begin
            rx_term_override <= next_override;
            rx_term_per_channel <= next_per_channel;
            rx_boost_select <= next_boost;
            tx_backterm_enable <= next_backterm;
            hs_output_enable <= next_hs_oe;
            tx_current_level <= next_current;
            tx_preemph_level <= next_preemph;
            hs_source_select <= next_hs_source;
            aux_source_select <= next_aux_source;
            aux_follow_hs <= next_aux_follow;
        end
    end

    assign slave_addr = addr;

    // ==================================================================
    // Input terminations: low half is source A, high half source B
    genvar g;
    generate
        for (g = 0; g < 2 * CHANNELS; g++) begin : term_gen
            localparam logic SRC = (g >= CHANNELS);
            always_ff @(posedge clk) begin
                if (rst) begin
                    rx_term_on[g] <= 1'h0;
                end else if (rx_term_override) begin
                    rx_term_on[g] <= rx_term_per_channel[g];
                end else begin
                    // Tracks the select so it follows every switch
                    rx_term_on[g] <= (hs_source_select == SRC);
                end
            end
        end
    endgenerate

    // ==================================================================
    // Hot-plug pulse; restart keeps the sink off across rapid switching
    av_switch_pkg::hpd_state_e hpd_state;
    av_switch_pkg::hpd_state_e next_hpd_state;
    logic [31:0] hpd_count;
    logic [31:0] next_hpd_count;
    logic switch_event;

    assign switch_event = wr_hs && (hs_source_select_in != hs_source_select);

    always_comb begin
        next_hpd_state = hpd_state;
        next_hpd_count = hpd_count;
        unique case (hpd_state)
            av_switch_pkg::hpd_idle: begin
                if (switch_event) begin
                    next_hpd_state = av_switch_pkg::hpd_pulse;
                    next_hpd_count = 32'h0;
                end
            end
            av_switch_pkg::hpd_pulse: begin
                if (switch_event) begin
                    next_hpd_count = 32'h0;
                end else if (hpd_count >= HPD_CYCLES - 1) begin
                    next_hpd_state = av_switch_pkg::hpd_idle;
                end else begin
                    next_hpd_count = hpd_count + 32'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hpd_state <= av_switch_pkg::hpd_idle;
            hpd_count <= 32'h0;
        end else begin
            hpd_state <= next_hpd_state;
            hpd_count <= next_hpd_count;
        end
    end

    // Released when idle, pulled low during the pulse
    assign hpd_a_out = 1'h0;
    assign hpd_b_out = 1'h0;
    assign hpd_a_oe = (hpd_state == av_switch_pkg::hpd_pulse);
    assign hpd_b_oe = (hpd_state == av_switch_pkg::hpd_pulse);

    // ==================================================================
    // Assertions
    sequence hs_write_s;
        !rst && wr_hs;
    endsequence

    hs_select_apply_a: assert property (@(posedge clk) disable iff (rst)
        hs_write_s |=> hs_source_select == $past(hs_source_select_in))
        else $error("high-speed select not applied");
    aux_follow_a: assert property (@(posedge clk) disable iff (rst)
        hs_write_s ##0 next_aux_follow
        |=> aux_source_select == $past(hs_source_select_in))
        else $error("aux select did not follow");
    auto_term_a: assert property (@(posedge clk) disable iff (rst)
        !rx_term_override && !wr_hs ##1 !rx_term_override
        |-> rx_term_on[0] == !hs_source_select
        && rx_term_on[CHANNELS] == hs_source_select)
        else $error("automatic termination wrong");
    manual_term_a: assert property (@(posedge clk) disable iff (rst)
        rx_term_override && !wr_rx ##1 rx_term_override
        |-> rx_term_on == rx_term_per_channel)
        else $error("manual termination wrong");
    hpd_start_a: assert property (@(posedge clk) disable iff (rst)
        switch_event |=> hpd_a_oe && hpd_b_oe && hpd_count == 32'h0)
        else $error("hot-plug pulse not started");
    hpd_length_a: assert property (@(posedge clk) disable iff (rst)
        $fell(hpd_a_oe) |-> $past(hpd_count) == HPD_CYCLES - 1)
        else $error("hot-plug pulse length wrong");
    reset_default_a: assert property (@(posedge clk)
        rst |=> rx_boost_select == `RST_BOOST_SELECT
        && tx_backterm_enable && tx_current_level)
        else $error("reset defaults wrong");
    addr_strap_a: assert property (@(posedge clk)
        ##1 slave_addr == {`SLAVE_ADDR_HIGH, $past(addr_select)})
        else $error("slave address wrong");
endmodule

//--- pkg/av_switch_map.svh
`ifndef AV_SWITCH_MAP_SVH
`define AV_SWITCH_MAP_SVH

// Slave address, upper six bits fixed, low bit from the strap
`define SLAVE_ADDR_HIGH 6'h24
// Reset values of the configuration bits
`define RST_BOOST_SELECT 8'hff
`define RST_TERM_OVERRIDE 1'h0
`define RST_TERM_PER_CHANNEL 8'h00
`define RST_BACKTERM 1'h1
`define RST_HS_OE 1'h0
`define RST_CURRENT_LEVEL 1'h1
`define RST_PREEMPH 2'h0
`define RST_HS_SOURCE 1'h0
`define RST_AUX_SOURCE 1'h0
`define RST_AUX_FOLLOW 1'h0
// Hot-plug low pulse: least time in ms and clock period in ns
`define HPD_LOW_MS 100
`define CLK_PERIOD_NS 10
`define HPD_LOW_CYCLES ((`HPD_LOW_MS * 1000000) / `CLK_PERIOD_NS + 1)

`endif

//--- pkg/av_switch_pkg.sv
package av_switch_pkg;
    // Source selection of the two-to-one switch
    typedef enum logic {
        source_a,
        source_b
    } source_e;
    // Hot-plug pulse states
    typedef enum logic {
        hpd_idle,
        hpd_pulse
    } hpd_state_e;
endpackage

//--- tb/host_model.sv
`timescale 1ns/1ns
// ==========
// Host model: writes settings just after the falling edge
module host_model #(
    parameter bit EXT_TERM = 1'b1
) (
    // Clock
    input wire logic clk,
    // Reset and strap
    output logic rst,
    output logic addr_select,
    // Receiver settings
    output logic wr_rx,
    output logic rx_term_override_in,
    output logic [7:0] rx_term_per_channel_in,
    output logic [7:0] rx_boost_select_in,
    // Transmitter settings
    output logic wr_tx,
    output logic tx_backterm_enable_in,
    output logic hs_output_enable_in,
    output logic tx_current_level_in,
    output logic [1:0] tx_preemph_level_in,
    // Source selection
    output logic wr_hs,
    output logic hs_source_select_in,
    output logic wr_aux,
    output logic aux_source_select_in,
    output logic aux_follow_hs_in
);
    // Everything quiet at time zero, reset asserted
    initial begin
        {addr_select, wr_rx, rx_term_override_in} = 3'h0;
        {rx_term_per_channel_in, rx_boost_select_in} = 16'h0000;
        {wr_tx, tx_backterm_enable_in, hs_output_enable_in} = 3'h0;
        {tx_current_level_in, tx_preemph_level_in} = 3'h0;
        {wr_hs, hs_source_select_in, wr_aux} = 3'h0;
        {aux_source_select_in, aux_follow_hs_in} = 2'h0;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
    end
    // Each write is one strobe cycle, taken at a single rising edge
    task automatic put_rx(input logic o, input logic [7:0] t, b);
        @(negedge clk);
        {rx_term_override_in, rx_term_per_channel_in} = {o, t};
        rx_boost_select_in = b;
        wr_rx = 1'b1;
        @(negedge clk);
        wr_rx = 1'b0;
    endtask
    // Current follows the internal terminations
    task automatic put_tx(input logic be, oe, input logic [1:0] pe);
        @(negedge clk);
        tx_backterm_enable_in = be;
        tx_current_level_in = be;
        hs_output_enable_in = oe & (be | EXT_TERM);
        tx_preemph_level_in = pe;
        wr_tx = 1'b1;
        @(negedge clk);
        wr_tx = 1'b0;
    endtask
    // Strap level; the host model is its only driver
    task automatic put_strap(input logic s);
        @(negedge clk);
        addr_select = s;
    endtask
    task automatic put_hs(input logic s);
        @(negedge clk);
        {wr_hs, hs_source_select_in} = {1'b1, s};
        @(negedge clk);
        wr_hs = 1'b0;
    endtask
    task automatic put_aux(input logic s, f);
        @(negedge clk);
        {wr_aux, aux_source_select_in, aux_follow_hs_in} = {1'b1, s, f};
        @(negedge clk);
        wr_aux = 1'b0;
    endtask
endmodule

//--- tb/test_av_link_switch_control.sv
`timescale 1ns/1ns
// ==========
// Bench
module test_av_link_switch_control;
    logic clk, rst, addr_select, wr_rx, rx_term_override_in, wr_tx;
    logic tx_backterm_enable_in, hs_output_enable_in, tx_current_level_in;
    logic wr_hs, hs_source_select_in, wr_aux, aux_source_select_in;
    logic aux_follow_hs_in, tx_backterm_enable, hs_output_enable;
    logic tx_current_level, hs_source_select, aux_source_select;
    logic hpd_a_out, hpd_a_oe, hpd_b_out, hpd_b_oe;
    logic [7:0] rx_term_per_channel_in, rx_boost_select_in;
    logic [7:0] rx_term_on, rx_boost_select;
    logic [1:0] tx_preemph_level_in, tx_preemph_level;
    logic [6:0] slave_addr;
    int n_fail = 0;
    int num_checks = 0;
    host_model host_model_inst (.clk, .rst, .addr_select, .wr_rx,
        .rx_term_override_in, .rx_term_per_channel_in, .rx_boost_select_in,
        .wr_tx, .tx_backterm_enable_in, .hs_output_enable_in,
        .tx_current_level_in, .tx_preemph_level_in, .wr_hs,
        .hs_source_select_in, .wr_aux, .aux_source_select_in,
        .aux_follow_hs_in);
    // Short pulse count keeps the run brief
    av_link_switch_control #(.HPD_CYCLES(8), .CHANNELS(4))
        av_link_switch_control_inst (.clk, .rst, .addr_select, .slave_addr,
        .wr_rx, .rx_term_override_in, .rx_term_per_channel_in,
        .rx_boost_select_in, .wr_tx, .tx_backterm_enable_in,
        .hs_output_enable_in, .tx_current_level_in, .tx_preemph_level_in,
        .wr_hs, .hs_source_select_in, .wr_aux, .aux_source_select_in,
        .aux_follow_hs_in, .rx_term_on, .rx_boost_select,
        .tx_backterm_enable, .hs_output_enable, .tx_current_level,
        .tx_preemph_level, .hs_source_select, .aux_source_select,
        .hpd_a_out, .hpd_a_oe, .hpd_b_out, .hpd_b_oe);
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        repeat (3) @(negedge clk);
        chk(rx_boost_select, 8'hff, "boost");
        chk(tx_backterm_enable, 1'h1, "backterm");
        chk(tx_current_level, 1'h1, "current");
        chk(rx_term_on, 8'h0f, "auto term");
        chk({hpd_a_oe, hpd_b_oe}, 2'h0, "hpd idle");
        $display("reset test done");
    endtask
    task automatic t_addr();
        host_model_inst.put_strap(1'b1);
        repeat (2) @(negedge clk);
        chk(slave_addr, 7'h49, "addr high");
        host_model_inst.put_strap(1'b0);
        repeat (2) @(negedge clk);
        chk(slave_addr, 7'h48, "addr low");
        $display("address test done");
    endtask
    task automatic t_tx();
        for (int i = 0; i < 4; i++) begin
            host_model_inst.put_tx(i[0], 1'b1, i[1:0]);
            chk(tx_backterm_enable, i[0], "backterm");
            chk(tx_current_level, i[0], "current");
            chk(tx_preemph_level, i[1:0], "preemph");
            chk(hs_output_enable, 1'h1, "hs on");
        end
        host_model_inst.put_tx(1'b1, 1'b0, 2'h0);
        chk(hs_output_enable, 1'h0, "hs off");
        $display("transmitter test done");
    endtask
    task automatic t_rx();
        host_model_inst.put_rx(1'b1, 8'ha5, 8'h3c);
        @(negedge clk);
        chk(rx_term_on, 8'ha5, "manual term");
        chk(rx_boost_select, 8'h3c, "boost bits");
        host_model_inst.put_rx(1'b0, 8'ha5, 8'hff);
        @(negedge clk);
        chk(rx_term_on, 8'h0f, "auto again");
        $display("receiver test done");
    endtask
    task automatic t_hs();
        host_model_inst.put_hs(1'b1);
        chk(hs_source_select, 1'h1, "hs select");
        @(negedge clk);
        chk({hpd_a_oe, hpd_b_oe}, 2'h3, "hpd low");
        chk({hpd_a_out, hpd_b_out}, 2'h0, "hpd level");
        chk(rx_term_on, 8'hf0, "term follows");
        repeat (3) @(negedge clk);
        host_model_inst.put_hs(1'b0);
        repeat (6) @(negedge clk);
        chk({hpd_a_oe, hpd_b_oe}, 2'h3, "restart");
        repeat (6) @(negedge clk);
        chk({hpd_a_oe, hpd_b_oe}, 2'h0, "released");
        chk(rx_term_on, 8'h0f, "term back");
        host_model_inst.put_hs(1'b0);
        @(negedge clk);
        chk({hpd_a_oe, hpd_b_oe}, 2'h0, "no switch");
        $display("switch test done");
    endtask
    task automatic t_aux();
        host_model_inst.put_aux(1'b1, 1'b0);
        chk(aux_source_select, 1'h1, "aux");
        chk(hs_source_select, 1'h0, "hs kept");
        host_model_inst.put_aux(1'b0, 1'b1);
        host_model_inst.put_hs(1'b1);
        chk(aux_source_select, 1'h1, "aux follows");
        $display("aux test done");
    endtask
    // Main sequence
    initial begin
        t_reset();
        t_addr();
        t_tx();
        t_rx();
        t_hs();
        t_aux();
        end_of_test();
    end
    // Watchdog, well past the expected run
    initial begin
        #20000;
        n_fail++;
        end_of_test();
    end
endmodule
